// ==== rtl/bf_guard_consts.svh ====
// Constants for the breaker failure guard: defaults, widths and tick timing
`ifndef BF_GUARD_CONSTS_SVH
`define BF_GUARD_CONSTS_SVH
`define BFG_CLK_HZ          125000000
`define BFG_TICK_MS         1
`define BFG_TICK_CYCLES     (`BFG_CLK_HZ / 1000 * `BFG_TICK_MS)
`define BFG_TIME_W          16
`define BFG_LEVEL_W         8
`define BFG_BACKUP_MS_DEF   16'h00C8
`define BFG_RETRIP_MS_DEF   16'h0064
`define BFG_PULSE_MS_DEF    16'h0064
`define BFG_PH_LEVEL_DEF    8'h1E
`define BFG_RES_LEVEL_DEF   8'h1E
`define BFG_MODE_OFF        2'h0
`define BFG_MODE_CURRENT    2'h1
`define BFG_MODE_CONTACT    2'h2
`define BFG_MODE_BOTH       2'h3
`endif

// ==== rtl/bf_guard_pkg.sv ====
// Types for the breaker failure guard
`include "bf_guard_consts.svh"
package bf_guard_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CURRENT,
    MODE_CONTACT,
    MODE_BOTH
  } guard_mode_t;
  typedef struct packed {
    logic [31:0]                    tick_cnt;
    logic                           tick;
    logic [2:0]                     start_prev;
    logic [2:0]                     cfg_taken;
    logic [2:0][`BFG_TIME_W-1:0]    backup_cnt;
    logic [2:0]                     backup_run;
    logic [2:0][`BFG_TIME_W-1:0]    retrip_cnt;
    logic [2:0]                     retrip_run;
    logic [2:0][`BFG_TIME_W-1:0]    bk_pulse_cnt;
    logic [2:0][`BFG_TIME_W-1:0]    rt_pulse_cnt;
    logic [2:0]                     backup_trip;
    logic [2:0]                     retrip;
    logic                           active;
  } guard_state_t;
endpackage

// ==== rtl/breaker_failure_guard.sv ====
// Breaker failure guard: per-phase backup and repeat trip supervision
`timescale 1ns/100ps
`include "bf_guard_consts.svh"
// Function
// - Start rising edge launches backup and retrip timers
// - Four modes, current supervision after reset
// - Fault checked only while timers run
// - Current mode ignores pole status inputs
// - Contact mode ignores current thresholds
// - Idle when all supervised conditions healthy, when blocked or off, or after expiry
// - Backup trip per phase on expiry
// - Backup delay in ms, default 200
// - Retrip pulse when enabled, own delay
// - Trip pulses last programmed pulse length
// - Phase current compared to phase level
// - Residual current compared to own level
module breaker_failure_guard
  import bf_guard_pkg::*;
#(
  parameter int TIME_W  = `BFG_TIME_W,
  parameter int LEVEL_W = `BFG_LEVEL_W,
  parameter int TICK_CYCLES = `BFG_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_sync_rst,
  // Settings
  input  wire logic [1:0]         i_mode,
  input  wire logic               i_retrip_en,
  input  wire logic [TIME_W-1:0]  i_backup_ms,
  input  wire logic [TIME_W-1:0]  i_retrip_ms,
  input  wire logic [TIME_W-1:0]  i_pulse_ms,
  input  wire logic [LEVEL_W-1:0] i_phase_pickup_level,
  input  wire logic [LEVEL_W-1:0] i_residual_pickup_level,
  // Process inputs
  input  wire logic [2:0]         i_start,
  input  wire logic               i_block,
  input  wire logic [2:0][LEVEL_W-1:0] i_phase_current,
  input  wire logic [LEVEL_W-1:0] i_residual_current,
  input  wire logic [2:0]         i_pole_closed,
  // Trip outputs
  output logic [2:0]              o_backup_trip,
  output logic [2:0]              o_retrip,
  output logic                    o_active
);

  // Registered state and its next value
  guard_state_t           state;
  guard_state_t           next_state;

  // Decoded settings
  logic                   cur_en;
  logic                   con_en;
  logic                   run_allowed;

  // Per-phase supervision terms
  logic                   res_over;
  logic [2:0]             phase_over;
  logic [2:0]             fault;
  logic [2:0]             start_rise;
  logic [2:0]             backup_keep;
  logic [2:0]             retrip_keep;

  // Timer steps: {next run, expiry, next count}; pulse steps: next count only
  logic [2:0][TIME_W+1:0] backup_step;
  logic [2:0][TIME_W+1:0] retrip_step;
  logic [2:0][TIME_W-1:0] bk_pulse_step;
  logic [2:0][TIME_W-1:0] rt_pulse_step;

  // Mode decode for the fault terms; the run gate compares i_mode with off directly
  function automatic logic mode_uses_current(input logic [1:0] mode);
    return (mode == `BFG_MODE_CURRENT) || (mode == `BFG_MODE_BOTH);
  endfunction

  function automatic logic mode_uses_contact(input logic [1:0] mode);
    return (mode == `BFG_MODE_CONTACT) || (mode == `BFG_MODE_BOTH);
  endfunction

  // Strict compare: a current equal to the pickup level counts as healthy
  function automatic logic above_level(
    input logic [LEVEL_W-1:0] level_now,
    input logic [LEVEL_W-1:0] pickup
  );
    return level_now > pickup;
  endfunction

  // One step of a supervision timer. It runs out only on a tick after reaching
  // zero, so a trip never comes early; it may come up to one tick late.
  function automatic logic [TIME_W+1:0] timer_step(
    input logic              run,
    input logic [TIME_W-1:0] cnt,
    input logic              keep,
    input logic              tick
  );
    logic              next_run;
    logic              expired;
    logic [TIME_W-1:0] next_cnt;
    next_run = run;
    expired  = 1'b0;
    next_cnt = cnt;
    if (run) begin
      if (!keep) begin
        next_run = 1'b0;
      end else if (tick && (cnt == '0)) begin
        next_run = 1'b0;
        expired  = 1'b1;
      end else if (tick) begin
        next_cnt = cnt - 1'b1;
      end
    end
    return {next_run, expired, next_cnt};
  endfunction

  // Field access for a timer step word
  function automatic logic step_run(input logic [TIME_W+1:0] step);
    return step[TIME_W+1];
  endfunction

  function automatic logic step_expired(input logic [TIME_W+1:0] step);
    return step[TIME_W];
  endfunction

  function automatic logic [TIME_W-1:0] step_count(input logic [TIME_W+1:0] step);
    return step[TIME_W-1:0];
  endfunction

  // Pulse counters count down one per tick and stop at zero
  function automatic logic [TIME_W-1:0] pulse_step(
    input logic [TIME_W-1:0] cnt,
    input logic              tick
  );
    logic [TIME_W-1:0] next_cnt;
    next_cnt = cnt;
    if (tick && (cnt != '0)) begin
      next_cnt = cnt - 1'b1;
    end
    return next_cnt;
  endfunction

  always_comb begin
    cur_en      = mode_uses_current(i_mode);
    con_en      = mode_uses_contact(i_mode);
    run_allowed = !i_block && (i_mode != `BFG_MODE_OFF);
  end

  assign res_over = above_level(i_residual_current, i_residual_pickup_level);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign phase_over[g] = above_level(i_phase_current[g], i_phase_pickup_level);
      // Any supervised condition keeps the phase faulty
      assign fault[g] = (cur_en && (phase_over[g] || res_over))
                     || (con_en && i_pole_closed[g]);
      assign start_rise[g]  = i_start[g] && !state.start_prev[g];
      assign backup_keep[g] = fault[g];
      // A retrip run also ends when its enable is withdrawn
      assign retrip_keep[g] = fault[g] && i_retrip_en;
      assign backup_step[g] = timer_step(state.backup_run[g], state.backup_cnt[g],
                                         backup_keep[g], state.tick);
      assign retrip_step[g] = timer_step(state.retrip_run[g], state.retrip_cnt[g],
                                         retrip_keep[g], state.tick);
      assign bk_pulse_step[g] = pulse_step(state.bk_pulse_cnt[g], state.tick);
      assign rt_pulse_step[g] = pulse_step(state.rt_pulse_cnt[g], state.tick);
    end
  endgenerate

  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    // Free-running divider: one tick per millisecond shared by every timer
    if (state.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_state.tick_cnt = 32'h0000_0000;
      next_state.tick     = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt + 32'h0000_0001;
    end
    next_state.start_prev = i_start;
    for (int p = 0; p < 3; p++) begin
      // Pulses in flight run on while blocked so a trip is never cut short
      next_state.bk_pulse_cnt[p] = bk_pulse_step[p];
      next_state.rt_pulse_cnt[p] = rt_pulse_step[p];
      if (!run_allowed) begin
        next_state.backup_run[p] = 1'b0;
        next_state.retrip_run[p] = 1'b0;
      end else if (start_rise[p]) begin
        next_state.backup_run[p] = 1'b1;
        next_state.retrip_run[p] = i_retrip_en;
        next_state.backup_cnt[p] = i_backup_ms;
        next_state.retrip_cnt[p] = i_retrip_ms;
      end else begin
        next_state.backup_run[p] = step_run(backup_step[p]);
        next_state.backup_cnt[p] = step_count(backup_step[p]);
        next_state.retrip_run[p] = step_run(retrip_step[p]);
        next_state.retrip_cnt[p] = step_count(retrip_step[p]);
        if (step_expired(backup_step[p])) begin
          next_state.bk_pulse_cnt[p] = i_pulse_ms;
        end
        if (step_expired(retrip_step[p])) begin
          next_state.rt_pulse_cnt[p] = i_pulse_ms;
        end
      end
      next_state.cfg_taken[p]   = next_state.backup_run[p] || next_state.retrip_run[p];
      next_state.backup_trip[p] = next_state.bk_pulse_cnt[p] != '0;
      next_state.retrip[p]      = next_state.rt_pulse_cnt[p] != '0;
    end
    next_state.active = |next_state.cfg_taken;
    if (i_sync_rst) begin
      next_state = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign o_backup_trip = state.backup_trip;
  assign o_retrip      = state.retrip;
  assign o_active      = state.active;

endmodule

// ==== testbench/bf_guard_monitor.sv ====
// Port timing checker for the breaker failure guard
`timescale 1ns/100ps
module bf_guard_monitor (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic        i_sync_rst,
  input wire logic [1:0]  i_mode,
  input wire logic        i_block,
  input wire logic [2:0]  i_start,
  input wire logic [15:0] i_pulse_ms,
  input wire logic [2:0]  o_backup_trip,
  input wire logic [2:0]  o_retrip,
  input wire logic        o_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_sync_clear: assert property (i_sync_rst |=> {o_active, o_backup_trip, o_retrip} == 7'h00)
    else $error("sync clear missed");
  a_active_cause: assert property ($rose(o_active) |-> $past(i_start) != 3'h0)
    else $error("active without start");
  a_block_idle: assert property (i_block |=> !o_active)
    else $error("active while blocked");
  a_mode_off: assert property (i_mode == 2'h0 |=> !o_active)
    else $error("active while off");
  a_backup_run: assert property ((o_backup_trip & ~$past(o_backup_trip)) != 3'h0 |-> $past(o_active))
    else $error("backup trip without timer");
  a_retrip_run: assert property ((o_retrip & ~$past(o_retrip)) != 3'h0 |-> $past(o_active))
    else $error("retrip without timer");
  // Assumes a tick of at least four cycles, as the bench sets
  a_backup_width: assert property ($rose(o_backup_trip[0]) && i_pulse_ms > 16'h0001 |-> o_backup_trip[0][*8])
    else $error("backup pulse short");
  a_retrip_width: assert property ($rose(o_retrip[0]) && i_pulse_ms > 16'h0001 |-> o_retrip[0][*8])
    else $error("retrip pulse short");
endmodule
bind breaker_failure_guard bf_guard_monitor i_mon (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_sync_rst(i_sync_rst), .i_mode(i_mode), .i_block(i_block), .i_start(i_start),
  .i_pulse_ms(i_pulse_ms), .o_backup_trip(o_backup_trip), .o_retrip(o_retrip), .o_active(o_active));

// ==== testbench/trip_source_model.sv ====
// Trip source and breaker contact model facing the guard
`timescale 1ns/100ps
module trip_source_model (
  input  wire logic       i_core_clk,
  input  wire logic [2:0] i_fire,
  input  wire logic       i_stuck,
  output logic      [2:0] o_start,
  output logic      [2:0] o_pole_closed
);
  // A healthy breaker opens at once; a stuck one stays closed
  always_ff @(posedge i_core_clk) begin
    o_start       <= i_fire;
    o_pole_closed <= {3{i_stuck}};
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the breaker failure guard
`timescale 1ns/100ps
module tb_top;
  logic i_core_clk = 0, i_arst_n = 0, i_sync_rst = 0, i_retrip_en = 0, i_block = 0, stuck = 0;
  logic [1:0] i_mode = 2'h1;
  logic [2:0] fire = 3'h0, i_start, i_pole_closed, o_backup_trip, o_retrip;
  logic [2:0][7:0] i_phase_current = '0;
  logic [7:0] i_residual_current = 8'h00, i_phase_pickup_level = 8'h1E, i_residual_pickup_level = 8'h1E;
  logic [15:0] i_backup_ms = 16'h0003, i_retrip_ms = 16'h0002, i_pulse_ms = 16'h0002;
  logic o_active;
  logic [31:0] seed = 32'h0000_9092;
  logic [6:0] tbl [9] = '{7'h31, 7'h24, 7'h28, 7'h58, 7'h45, 7'h64, 7'h60, 7'h1C, 7'h3E};
  int errors = 0, num_checks = 0;
  always #4 i_core_clk = ~i_core_clk;
  breaker_failure_guard #(.TICK_CYCLES(10)) i_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sync_rst(i_sync_rst), .i_mode(i_mode),
    .i_retrip_en(i_retrip_en), .i_backup_ms(i_backup_ms), .i_retrip_ms(i_retrip_ms),
    .i_pulse_ms(i_pulse_ms), .i_phase_pickup_level(i_phase_pickup_level),
    .i_residual_pickup_level(i_residual_pickup_level), .i_start(i_start), .i_block(i_block),
    .i_phase_current(i_phase_current), .i_residual_current(i_residual_current),
    .i_pole_closed(i_pole_closed), .o_backup_trip(o_backup_trip), .o_retrip(o_retrip),
    .o_active(o_active));
  trip_source_model i_src (.i_core_clk(i_core_clk), .i_fire(fire), .i_stuck(stuck),
    .o_start(i_start), .o_pole_closed(i_pole_closed));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Strict compare: a level of exactly 30 is healthy
  function logic [7:0] lvl(input logic hi);
    return hi ? 8'h1F + 8'(xs() % 64) : 8'h1E - 8'(xs() & 1);
  endfunction
  function logic fault(input logic [6:0] c);
    return ((c[5] & (c[4] | c[3])) | (c[6] & c[2])) & ~c[1];
  endfunction
  task chk(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic run(input logic [6:0] c);
    logic x;
    int t0, w, ph;
    logic r, s;
    x = fault(c);
    t0 = 0;
    w = 0;
    r = 0;
    s = 0;
    ph = int'(xs() % 3);
    @(posedge i_core_clk);
    i_mode <= c[6:5];
    i_phase_current <= {3{lvl(c[4])}};
    i_residual_current <= lvl(c[3]);
    stuck <= c[2];
    i_block <= c[1];
    i_retrip_en <= c[0];
    fire <= 3'(1 << ph);
    for (int k = 1; k < 120; k++) begin
      @(negedge i_core_clk);
      if (k == 4) chk("active", x, o_active);
      if (o_backup_trip[ph] === 1'b1 && t0 == 0) t0 = k;
      if (o_backup_trip[ph] === 1'b1) w++;
      if (o_retrip[ph] === 1'b1) r = 1;
      if (((o_backup_trip | o_retrip) & ~fire) != 3'h0) s = 1;
    end
    chk("backup trip", x, w != 0);
    chk("retrip", x & c[0], r);
    chk("other phases", 1'b0, s);
    // Start seen at cycle 3; 3 ms delay may run up to one tick late, never early
    if (x) chk("trip time", 1'b1, t0 > 32 && t0 < 45);
    if (x) chk("pulse width", 1'b1, w > 18 && w < 22);
    @(posedge i_core_clk);
    fire <= 3'h0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge i_core_clk);
    errors++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(posedge i_core_clk) i_sync_rst <= 1'b1;
    @(posedge i_core_clk) i_sync_rst <= 1'b0;
    for (int i = 0; i < 15; i++) run(i < 9 ? tbl[i] : 7'(xs()));
    // Mid-run clear: a running timer must drop and never trip
    @(posedge i_core_clk);
    i_mode <= 2'h1;
    i_block <= 1'b0;
    i_phase_current <= {3{8'h50}};
    fire <= 3'h4;
    repeat (8) @(posedge i_core_clk);
    i_sync_rst <= 1'b1;
    fire <= 3'h0;
    @(negedge i_core_clk);
    chk("active before clear", 1'b1, o_active);
    @(posedge i_core_clk);
    i_sync_rst <= 1'b0;
    @(negedge i_core_clk);
    chk("active after clear", 1'b0, o_active);
    repeat (60) @(negedge i_core_clk);
    chk("trip after clear", 1'b0, o_backup_trip[2]);
    finish_test;
  end
endmodule
